// *** logic/opmode_params.svh ***
`ifndef OPMODE_PARAMS_SVH
`define OPMODE_PARAMS_SVH
// ==========================================
// Register byte addresses
`define ADDR_CTRL      8'h00
`define ADDR_MAP0      8'h04
`define ADDR_MAP1      8'h08
`define ADDR_DIAGCFG   8'h0c
`define ADDR_STATUS    8'h10
`define ADDR_ERR       8'h14
// ==========================================
// Control fields
`define CTRL_KEEP_BIT  8
`define CTRL_RST_BIT   9
`define CTRL_PWM0_BIT  10
`define CTRL_PWM1_BIT  11
`define CTRL_WIDTH     12
`define DCFG_OPEN_LOAD_ON_ENABLE_BIT  0
`define DCFG_OPEN_LOAD_OFF_ENABLE_BIT 1
// ==========================================
// Status fields
`define STAT_UV_BIT    2
`define STAT_LOP_BIT   3
`define STAT_TER_BIT   4
// ==========================================
// Reset values and masks
`define CTRL_RESET     12'h000
`define MAP0_RESET     8'h04
`define MAP1_RESET     8'h08
`define DCFG_RESET     2'h0
`define LIMP_CH_MASK   8'h0c
`define CH_OFF         8'h00
// ==========================================
// Mode field codes
`define MODE_IDLE      2'h0
`define MODE_LIMP      2'h1
`define MODE_ACTIVE    2'h2
`define MODE_SLEEP     2'h3
// ==========================================
// Timing
`define CLK_MHZ        25
`define WAKE_NS        2000
`define WAKE_CYC       ((`WAKE_NS * `CLK_MHZ + 999) / 1000)
`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2
`endif

// *** logic/opmode_pkg.sv ***
`default_nettype none
package opmode_pkg;
  typedef enum logic [2:0] {SLEEP, IDLE, WAKE, ACTIVE, LIMP} mode_t;
  typedef struct packed {
    logic vddUv;
    logic vddLow;
    logic vsUv;
    logic vsOk;
  } supply_t;
endpackage
`default_nettype wire

// *** logic/operation_mode_controller.sv ***
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`include "opmode_params.svh"
`default_nettype none
// Function
// - Standby high plus input pin or channel-on bit enters Active.
// - Keep-active clear: all pins low, channel bits zero returns to Idle.
// - Keep-active set keeps Active regardless of pins and channel bits.
// - Logic-supply undervoltage sends to Idle when all pins low.
// - Any input pin high enters Active even with empty mappings.
// - Standby low with a pin high enters Limp Home, driving its channel.
// - Limp Home allows reads but ignores all register writes.
// - Limp Home reports undervoltage and low-logic-supply flags as one.
// - Limp Home reports mode field as binary 01.
// - Transmission error reads one on first access after Limp entry.
// - Limp Home forces open-load enables off; errors, monitors stay live.
// - Other registers read default and refuse programming in Limp Home.
// - Limp Home drives only channels 2 and 3 from pins.
// - Sleep keeps outputs off and registers at reset values.
// - Idle disables diagnosis, channels off, registers usable unless entered on logic undervoltage.
// - Idle leaves channel error bits uncleared.
// - Registers reset on logic undervoltage, standby low or reset command.
// - Reset command keeps error bits, clears supply flags.
// - Register reset drops channels without pin and restores mappings.
// - Load undervoltage while operating sets undervoltage flag.
// - Undervoltage flag clears on status readout once supply recovered.
// - Low-logic flag set in low range, cleared on readout after.
module operation_mode_controller (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              standbyPin,
  input  wire logic [1:0]        directInputPin,
  input  wire opmode_pkg::supply_t supplyIn,
  input  wire logic [7:0]        chanErrSet,
  input  wire logic [7:0]        outStatusMon,
  input  wire logic              xferErr,
  output logic [7:0]             chanOut,
  output logic [1:0]             modeCode,
  output logic                   diagEnable,
  output logic                   openLoadOnEn,
  output logic                   openLoadOffEn,
  output logic                   pwmGenZeroEn,
  output logic                   pwmGenOneEn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ==========================================
  // Pin synchronisers
  logic [6:0]            syncA_r;
  logic [6:0]            syncB_r;
  logic                  stby;
  logic [1:0]            pinIn;
  opmode_pkg::supply_t   sup;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      syncA_r <= 7'h00;
      syncB_r <= 7'h00;
    end
    else
    begin
      syncA_r <= {standbyPin, directInputPin, supplyIn};
      syncB_r <= syncA_r;
    end
  end

  assign stby  = syncB_r[6];
  assign pinIn = syncB_r[5:4];
  assign sup   = opmode_pkg::supply_t'(syncB_r[3:0]);

  // ==========================================
  // Declarations
  opmode_pkg::mode_t     mode_r;
  opmode_pkg::mode_t     mode_nxt;
  opmode_pkg::mode_t     target;
  logic [7:0]            wakeCnt_r;
  logic [`CTRL_WIDTH-1:0] ctrl_r;
  logic [7:0]            map0_r;
  logic [7:0]            map1_r;
  logic [1:0]            dcfg_r;
  logic [7:0]            err_r;
  logic                  uvFlag_r;
  logic                  lopFlag_r;
  logic                  terFlag_r;
  logic                  limpFirst_r;
  logic                  anyIn;
  logic                  inLimp;
  logic                  operating;
  logic [7:0]            awAddr_r;
  logic                  awHeld_r;
  logic [31:0]           wData_r;
  logic [3:0]            wStrb_r;
  logic                  wHeld_r;
  logic                  doWrite;
  logic                  doRead;
  logic                  wrEn;
  logic                  rstCmd;
  logic                  regReset;
  logic                  statusRead;
  logic [7:0]            pinMapped;
  logic [31:0]           rdData;
  logic [1:0]            modeField;

  assign anyIn     = |pinIn;
  assign inLimp    = (mode_r == opmode_pkg::LIMP);
  assign operating = (mode_r == opmode_pkg::ACTIVE) || inLimp;

  // ==========================================
  // Mode state machine
  always_comb
  begin
    if (!stby)
      target = anyIn ? opmode_pkg::LIMP : opmode_pkg::SLEEP;
    else if (anyIn)
      target = opmode_pkg::ACTIVE;
    else if (sup.vddUv)
      target = opmode_pkg::IDLE;
    else if (ctrl_r[`CTRL_KEEP_BIT])
      target = opmode_pkg::ACTIVE;
    else if (|ctrl_r[7:0])
      target = opmode_pkg::ACTIVE;
    else
      target = opmode_pkg::IDLE;
  end

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      opmode_pkg::SLEEP, opmode_pkg::IDLE:
      begin
        if (target == opmode_pkg::ACTIVE || target == opmode_pkg::LIMP)
          mode_nxt = opmode_pkg::WAKE;
        else
          mode_nxt = target;
      end
      opmode_pkg::WAKE:
      begin
        if (target != opmode_pkg::ACTIVE && target != opmode_pkg::LIMP)
          mode_nxt = target;
        else if (wakeCnt_r == 8'h00)
          mode_nxt = target;
      end
      default:
        mode_nxt = target;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      mode_r <= opmode_pkg::SLEEP;
    else
      mode_r <= mode_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      wakeCnt_r <= 8'h00;
    else if (mode_r != opmode_pkg::WAKE)
      wakeCnt_r <= 8'(`WAKE_CYC - 1);
    else if (wakeCnt_r != 8'h00)
      wakeCnt_r <= wakeCnt_r - 8'h01;
  end

  // ==========================================
  // AXI4-Lite slave
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign doRead  = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      awHeld_r      <= 1'b0;
      awAddr_r      <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !awHeld_r && !(s_axi_awvalid && s_axi_awready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      else if (doWrite)
        awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wHeld_r      <= 1'b0;
      wData_r      <= 32'h0000_0000;
      wStrb_r      <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_wready <= !wHeld_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      else if (doWrite)
        wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      if (awAddr_r == `ADDR_CTRL || awAddr_r == `ADDR_MAP0 || awAddr_r == `ADDR_MAP1 ||
          awAddr_r == `ADDR_DIAGCFG || awAddr_r == `ADDR_ERR || awAddr_r == `ADDR_STATUS)
        s_axi_bresp <= `AXI_OKAY;
      else
        s_axi_bresp <= `AXI_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Writes land only outside Limp Home and with a live register file
  assign wrEn   = doWrite && !inLimp && wStrb_r[0] && !sup.vddUv && stby;
  assign rstCmd = wrEn && awAddr_r == `ADDR_CTRL && wStrb_r[1] &&
                  wData_r[`CTRL_RST_BIT];
  assign regReset = sup.vddUv || !stby || rstCmd ||
                    mode_r == opmode_pkg::SLEEP || inLimp;

  // ==========================================
  // Configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (srst || regReset)
    begin
      ctrl_r <= `CTRL_RESET;
      map0_r <= `MAP0_RESET;
      map1_r <= `MAP1_RESET;
      dcfg_r <= `DCFG_RESET;
    end
    else if (wrEn)
    begin
      if (awAddr_r == `ADDR_CTRL)
      begin
        ctrl_r[7:0] <= wData_r[7:0];
        if (wStrb_r[1])
          ctrl_r[`CTRL_WIDTH-1:8] <= wData_r[`CTRL_WIDTH-1:8] &
                                     ~(4'h1 << (`CTRL_RST_BIT - 8));
      end
      else if (awAddr_r == `ADDR_MAP0)
        map0_r <= wData_r[7:0];
      else if (awAddr_r == `ADDR_MAP1)
        map1_r <= wData_r[7:0];
      else if (awAddr_r == `ADDR_DIAGCFG)
        dcfg_r <= wData_r[1:0];
    end
  end

  // ==========================================
  // Error and supply flags
  assign statusRead = doRead && s_axi_araddr == `ADDR_STATUS;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      err_r <= 8'h00;
    else
      err_r <= chanErrSet | (err_r & ~((wrEn && awAddr_r == `ADDR_ERR) ?
               wData_r[7:0] : 8'h00));
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      uvFlag_r <= 1'b0;
    else if (operating && sup.vsUv)
      uvFlag_r <= 1'b1;
    else if (rstCmd)
      uvFlag_r <= 1'b0;
    else if (statusRead && sup.vsOk)
      uvFlag_r <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      lopFlag_r <= 1'b0;
    else if (sup.vddLow)
      lopFlag_r <= 1'b1;
    else if (rstCmd)
      lopFlag_r <= 1'b0;
    else if (statusRead)
      lopFlag_r <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      terFlag_r <= 1'b0;
    else if (xferErr)
      terFlag_r <= 1'b1;
    else if (statusRead)
      terFlag_r <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      limpFirst_r <= 1'b0;
    else if (mode_nxt == opmode_pkg::LIMP && !inLimp)
      limpFirst_r <= 1'b1;
    else if (doRead || (s_axi_wvalid && s_axi_wready))
      limpFirst_r <= 1'b0;
  end

  // ==========================================
  // Read path
  always_comb
  begin
    case (mode_r)
      opmode_pkg::LIMP:   modeField = `MODE_LIMP;
      opmode_pkg::ACTIVE: modeField = `MODE_ACTIVE;
      opmode_pkg::SLEEP:  modeField = `MODE_SLEEP;
      default:            modeField = `MODE_IDLE;
    endcase
  end

  always_comb
  begin
    rdData = 32'h0000_0000;
    if (s_axi_araddr == `ADDR_CTRL)
      rdData[`CTRL_WIDTH-1:0] = ctrl_r;
    else if (s_axi_araddr == `ADDR_MAP0)
      rdData[7:0] = map0_r;
    else if (s_axi_araddr == `ADDR_MAP1)
      rdData[7:0] = map1_r;
    else if (s_axi_araddr == `ADDR_DIAGCFG)
      rdData[1:0] = inLimp ? 2'h0 : dcfg_r;
    else if (s_axi_araddr == `ADDR_STATUS)
    begin
      rdData[1:0]           = modeField;
      rdData[`STAT_UV_BIT]  = uvFlag_r || inLimp;
      rdData[`STAT_LOP_BIT] = lopFlag_r || inLimp;
      rdData[`STAT_TER_BIT] = terFlag_r || (limpFirst_r && inLimp);
    end
    else if (s_axi_araddr == `ADDR_ERR)
      rdData[15:0] = {outStatusMon, err_r};
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !doRead;
      if (doRead)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdData;
        if (s_axi_araddr == `ADDR_CTRL || s_axi_araddr == `ADDR_MAP0 ||
            s_axi_araddr == `ADDR_MAP1 || s_axi_araddr == `ADDR_DIAGCFG ||
            s_axi_araddr == `ADDR_STATUS || s_axi_araddr == `ADDR_ERR)
          s_axi_rresp <= `AXI_OKAY;
        else
          s_axi_rresp <= `AXI_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // Channel and diagnosis outputs
  assign pinMapped = (pinIn[0] ? map0_r : 8'h00) | (pinIn[1] ? map1_r : 8'h00);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      chanOut       <= `CH_OFF;
      modeCode      <= `MODE_SLEEP;
      diagEnable    <= 1'b0;
      openLoadOnEn  <= 1'b0;
      openLoadOffEn <= 1'b0;
      pwmGenZeroEn  <= 1'b0;
      pwmGenOneEn   <= 1'b0;
    end
    else
    begin
      modeCode <= modeField;
      case (mode_r)
        opmode_pkg::ACTIVE:
          chanOut <= ctrl_r[7:0] | pinMapped;
        opmode_pkg::LIMP:
          chanOut <= pinMapped & `LIMP_CH_MASK;
        default:
          chanOut <= `CH_OFF;
      endcase
      diagEnable    <= operating;
      openLoadOnEn  <= operating && !inLimp && dcfg_r[`DCFG_OPEN_LOAD_ON_ENABLE_BIT];
      openLoadOffEn <= operating && !inLimp && dcfg_r[`DCFG_OPEN_LOAD_OFF_ENABLE_BIT];
      pwmGenZeroEn  <= (mode_r == opmode_pkg::ACTIVE) && ctrl_r[`CTRL_PWM0_BIT];
      pwmGenOneEn   <= (mode_r == opmode_pkg::ACTIVE) && ctrl_r[`CTRL_PWM1_BIT];
    end
  end

endmodule
`default_nettype wire

// *** tb/mcu_pin_model.sv ***
`default_nettype none
module mcu_pin_model (
  input  wire logic                sys_clk,
  output var  logic                standbyPin,
  output var  logic [1:0]          directInputPin,
  output var  opmode_pkg::supply_t supplyIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Pin and supply levels, changed just after an edge
  initial
  begin
    standbyPin = 1'h0;
    directInputPin = 2'h0;
    supplyIn = 4'h1;
  end
  // Some callers go straight to a bus access without waiting for a mode to settle
  task automatic setPins(input logic s, input logic [1:0] p, input logic [3:0] v);
    @(posedge sys_clk);
    standbyPin <= s;
    directInputPin <= p;
    supplyIn <= v;
  endtask
endmodule
`default_nettype wire

// *** tb/operation_mode_controller_chk.sv ***
`include "opmode_params.svh"
`default_nettype none
module opmode_chk (
  input wire logic                sys_clk,
  input wire logic                srst,
  input wire logic                standbyPin,
  input wire logic [1:0]          directInputPin,
  input wire opmode_pkg::supply_t supplyIn,
  input wire logic [7:0]          chanOut,
  input wire logic [1:0]          modeCode,
  input wire logic                diagEnable,
  input wire logic                openLoadOnEn,
  input wire logic                openLoadOffEn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================
  // Requests held past the synchronisers
  sequence sLimpReq;
    (!standbyPin && |directInputPin) [*4];
  endsequence
  sequence sActReq;
    (standbyPin && |directInputPin) [*4];
  endsequence
  sequence sUvReq;
    (supplyIn.vddUv && standbyPin && !(|directInputPin)) [*4];
  endsequence
  sequence sIn(logic [1:0] m);
    (modeCode == m) [*3];
  endsequence
  // ==========================================
  // Length of the current run of mode field 00
  logic [7:0] idleRun_r;
  always_ff @(posedge sys_clk)
  begin
    if (srst || modeCode != 2'h0)
      idleRun_r <= 8'h00;
    else if (idleRun_r != 8'hff)
      idleRun_r <= idleRun_r + 8'h01;
  end
  // ==========================================
  // Mode checks
  a_act_entry: assert property (sActReq |-> ##[0:70] modeCode == 2'h2)
    else $error("pin request did not reach active");
  a_uv_idle: assert property (sUvReq |-> ##[0:8] modeCode == 2'h0)
    else $error("logic undervoltage did not reach idle");
  a_limp_entry: assert property (sLimpReq |-> ##[0:70] modeCode == 2'h1)
    else $error("limp request did not reach limp home");
  a_limp_noopen: assert property (sIn(2'h1) |-> !openLoadOnEn && !openLoadOffEn)
    else $error("open load enable high in limp home");
  a_limp_chans: assert property (sIn(2'h1) |-> (chanOut & 8'hf3) == 8'h00)
    else $error("channel other than 2 or 3 on in limp home");
  a_sleep_off: assert property (sIn(2'h3) |-> chanOut == 8'h00 && !diagEnable)
    else $error("output or diagnosis on in sleep");
  a_idle_off: assert property (sIn(2'h0) |-> chanOut == 8'h00 && !diagEnable)
    else $error("output or diagnosis on in idle");
  a_wake_delay: assert property (modeCode == 2'h2 && $past(modeCode) == 2'h0
    |-> idleRun_r >= 8'(`WAKE_CYC - 3))
    else $error("active reached before wake delay");
endmodule
bind operation_mode_controller opmode_chk u_opmode_chk (.sys_clk, .srst, .standbyPin,
  .directInputPin, .supplyIn, .chanOut, .modeCode, .diagEnable, .openLoadOnEn, .openLoadOffEn);
`default_nettype wire

// *** tb/operation_mode_controller_test.sv ***
`include "opmode_params.svh"
`default_nettype none
module operation_mode_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                sys_clk = 1'h0;
  logic                srst = 1'h1;
  wire logic           standbyPin;
  wire logic [1:0]     directInputPin;
  opmode_pkg::supply_t supplyIn;
  logic [7:0]          chanErrSet = 8'h00;
  logic [7:0]          outStatusMon = 8'ha5;
  logic                xferErr = 1'h0;
  logic [7:0]          chanOut;
  logic [1:0]          modeCode;
  logic                diagEnable, openLoadOnEn, openLoadOffEn, pwmGenZeroEn, pwmGenOneEn;
  logic [7:0]          s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]         s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic                s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  int                  fails = 0;
  int                  num_checks = 0;
  always #20 sys_clk = ~sys_clk;
  operation_mode_controller u_operation_mode_controller (.*);
  mcu_pin_model u_mcu_pin_model (.sys_clk, .standbyPin, .directInputPin, .supplyIn);
  // ==========================================
  // Reporting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic conclude();
    $display("%0d checks, %0d mismatches", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic hang();
    fails++;
    conclude();
  endtask
  // ==========================================
  // Bus and pin access
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; !s_axi_bvalid; n++)
    begin
      if (n == 50)
        hang();
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; !s_axi_rvalid; n++)
    begin
      if (n == 50)
        hang();
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  task automatic waitMode(input logic [1:0] m);
    int n;
    logic [1:0] start;
    start = modeCode;
    for (n = 0; modeCode !== m; n++)
    begin
      if (n == 300)
        hang();
      @(posedge sys_clk);
    end
    chk(32'(n > `WAKE_CYC - 5 || m != `MODE_ACTIVE || start == `MODE_LIMP), 32'h1);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic pins(input logic s, input logic [1:0] p, input logic [3:0] v);
    u_mcu_pin_model.setPins(s, p, v);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    chk(32'({modeCode, chanOut}), 32'h300);
    wr(`ADDR_CTRL, 32'h1, `AXI_OKAY);
    rd(`ADDR_CTRL, 32'h0, `AXI_OKAY);
    $display("sleep test done");
    pins(1'h1, 2'h0, 4'h1);
    waitMode(`MODE_IDLE);
    wr(`ADDR_CTRL, 32'h1, `AXI_OKAY);
    waitMode(`MODE_ACTIVE);
    chk(32'(chanOut), 32'h1);
    wr(`ADDR_CTRL, 32'h0, `AXI_OKAY);
    waitMode(`MODE_IDLE);
    wr(`ADDR_CTRL, 32'h100, `AXI_OKAY);
    waitMode(`MODE_ACTIVE);
    pins(1'h1, 2'h1, 4'h1);
    pins(1'h1, 2'h0, 4'h1);
    repeat (10) @(posedge sys_clk);
    chk(32'(modeCode), 32'h2);
    wr(`ADDR_CTRL, 32'h200, `AXI_OKAY);
    rd(`ADDR_CTRL, 32'h0, `AXI_OKAY);
    waitMode(`MODE_IDLE);
    $display("idle and active test done");
    wr(`ADDR_MAP0, 32'h0, `AXI_OKAY);
    wr(`ADDR_MAP1, 32'h0, `AXI_OKAY);
    pins(1'h1, 2'h1, 4'h1);
    waitMode(`MODE_ACTIVE);
    chk(32'(chanOut), 32'h0);
    pins(1'h1, 2'h0, 4'h1);
    waitMode(`MODE_IDLE);
    @(posedge sys_clk);
    chanErrSet <= 8'h20;
    @(posedge sys_clk);
    chanErrSet <= 8'h00;
    pins(1'h0, 2'h3, 4'h1);
    waitMode(`MODE_LIMP);
    chk(32'(chanOut), 32'hc);
    rd(`ADDR_STATUS, 32'h1d, `AXI_OKAY);
    rd(`ADDR_STATUS, 32'h0d, `AXI_OKAY);
    wr(`ADDR_DIAGCFG, 32'h3, `AXI_OKAY);
    rd(`ADDR_DIAGCFG, 32'h0, `AXI_OKAY);
    rd(`ADDR_ERR, 32'ha520, `AXI_OKAY);
    pins(1'h1, 2'h3, 4'h1);
    waitMode(`MODE_ACTIVE);
    rd(`ADDR_MAP0, 32'h4, `AXI_OKAY);
    pins(1'h1, 2'h0, 4'h1);
    waitMode(`MODE_IDLE);
    rd(`ADDR_ERR, 32'ha520, `AXI_OKAY);
    wr(`ADDR_CTRL, 32'h200, `AXI_OKAY);
    rd(`ADDR_ERR, 32'ha520, `AXI_OKAY);
    wr(`ADDR_ERR, 32'h20, `AXI_OKAY);
    rd(`ADDR_ERR, 32'ha500, `AXI_OKAY);
    $display("limp home test done");
    wr(`ADDR_CTRL, 32'h1, `AXI_OKAY);
    waitMode(`MODE_ACTIVE);
    wr(`ADDR_DIAGCFG, 32'h3, `AXI_OKAY);
    wr(`ADDR_CTRL, 32'hc01, `AXI_OKAY);
    repeat (2) @(posedge sys_clk);
    chk(32'({pwmGenOneEn, pwmGenZeroEn, openLoadOffEn, openLoadOnEn, diagEnable}), 32'h1f);
    @(posedge sys_clk);
    xferErr <= 1'h1;
    @(posedge sys_clk);
    xferErr <= 1'h0;
    rd(`ADDR_STATUS, 32'h12, `AXI_OKAY);
    rd(`ADDR_STATUS, 32'h2, `AXI_OKAY);
    pins(1'h1, 2'h0, 4'h2);
    repeat (5) @(posedge sys_clk);
    rd(`ADDR_STATUS, 32'h6, `AXI_OKAY);
    pins(1'h1, 2'h0, 4'h1);
    repeat (5) @(posedge sys_clk);
    rd(`ADDR_STATUS, 32'h6, `AXI_OKAY);
    rd(`ADDR_STATUS, 32'h2, `AXI_OKAY);
    pins(1'h1, 2'h0, 4'h5);
    repeat (5) @(posedge sys_clk);
    pins(1'h1, 2'h0, 4'h1);
    repeat (5) @(posedge sys_clk);
    rd(`ADDR_STATUS, 32'ha, `AXI_OKAY);
    rd(`ADDR_STATUS, 32'h2, `AXI_OKAY);
    pins(1'h1, 2'h0, 4'h5);
    repeat (5) @(posedge sys_clk);
    pins(1'h1, 2'h0, 4'h1);
    repeat (5) @(posedge sys_clk);
    wr(`ADDR_CTRL, 32'h200, `AXI_OKAY);
    waitMode(`MODE_IDLE);
    rd(`ADDR_STATUS, 32'h0, `AXI_OKAY);
    wr(`ADDR_CTRL, 32'h1, `AXI_OKAY);
    waitMode(`MODE_ACTIVE);
    pins(1'h1, 2'h0, 4'h9);
    waitMode(`MODE_IDLE);
    wr(`ADDR_CTRL, 32'h1, `AXI_OKAY);
    rd(`ADDR_CTRL, 32'h0, `AXI_OKAY);
    pins(1'h1, 2'h0, 4'h1);
    wr(8'h20, 32'h1, `AXI_SLVERR);
    rd(8'h20, 32'h0, `AXI_SLVERR);
    $display("supply test done");
    conclude();
  end
endmodule
`default_nettype wire
